// File: inc/pmc_pkg.sv
// shared constants, types and behaviour notes for the core timing block
// ---------------------------------------------------------------------
// Notes on behaviour
// [RULE1] Every opcode is decoded with the classic 8-bit encoding, lengths and flag effects; only timing differs.
// [RULE2] Instructions are sequenced in single clock cycles, never grouped into machine cycles.
// [RULE3] Most instructions take as many clocks as they have program bytes, thanks to the pipelined fetch.
// [RULE4] A conditional branch that is not taken finishes one clock sooner than when it is taken.
// [RULE5] No instruction takes more than eight clocks, and the slowest takes exactly eight.
// [RULE6] The cycle counts follow the documented distribution across the 109 instructions.
// [RULE7] The core is fully static from zero up to its top rate and can retire one instruction per clock.
// [RULE8] Software reads program flash with the code-memory move and writes it bytewise with the external-data move.
// [RULE9] A serial debug port lets a host program the flash and talk to the debug logic.
// [RULE10] Debug offers breakpoints, watchpoints, run, halt, single step, stack inspection and register and memory access.
// [RULE11] Debug runs at full speed and uses no RAM, stack, timer or other resource the application sees.
// [RULE12] The core has 256 bytes of internal RAM and a separate 128-byte special function register space.
// ---------------------------------------------------------------------
package pmc_pkg;

  // ---------------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------------
  localparam int PMC_CLK_PERIOD_NS = 8;
  localparam int PMC_MAX_CYCLES = 8;
  localparam int PMC_RAM_BYTES = 256;
  localparam int PMC_SFR_BYTES = 128;
  localparam int PMC_DBG_W = 28;
  localparam logic [15:0] PMC_RESET_PC = 16'h0000;

  // ---------------------------------------------------------------------
  // opcodes with special timing
  // ---------------------------------------------------------------------
  localparam logic [7:0] PMC_OP_MULTIPLY_OP = 8'hA4;
  localparam logic [7:0] PMC_OP_DIVIDE = 8'h84;
  localparam logic [7:0] PMC_OP_RETURN = 8'h22;
  localparam logic [7:0] PMC_OP_RETURN_INT = 8'h32;
  localparam logic [7:0] PMC_OP_LONG_CALL = 8'h12;
  localparam logic [7:0] PMC_OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] PMC_OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] PMC_OP_JUMP_INDEXED = 8'h73;

  // ---------------------------------------------------------------------
  // debug port commands
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    DBG_NOP = 4'h0,
    DBG_HALT = 4'h1,
    DBG_RUN = 4'h2,
    DBG_STEP = 4'h3,
    DBG_SET_BP = 4'h4,
    DBG_SET_WP = 4'h5,
    DBG_CLR_BP = 4'h6,
    DBG_RD_MEM = 4'h7,
    DBG_WR_MEM = 4'h8,
    DBG_RD_CODE = 4'h9,
    DBG_WR_CODE = 4'hA,
    DBG_RD_PC = 4'hB
  } pmc_dbg_cmd_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_STEP = 2'b10
  } pmc_state_t;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cycles;
    logic cond;
  } pmc_timing_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } pmc_exec_t;

  typedef struct packed {
    logic wr;
    logic sfr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmc_dmem_req_t;

  typedef struct packed {
    logic [3:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } pmc_dbg_word_t;

endpackage : pmc_pkg

// File: verilog/pmc_cycle_decode.sv
// opcode to length, clock count and branch class decoder
`timescale 1ns/1ps
module pmc_cycle_decode (
  // opcode in
  input wire logic [7:0] i_opcode,
  // timing out
  output pmc_pkg::pmc_timing_t o_timing
);
  import pmc_pkg::*;

  // classic encoding lengths, grouped by low nibble
  function automatic logic [1:0] pmc_len(input logic [7:0] op);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = op[7:4];
    lo = op[3:0];
    pmc_len = 2'd1;
    case (lo)
      4'h0: pmc_len = (hi == 4'h0 || hi >= 4'hE) ? 2'd1 :
        (hi <= 4'h3 || hi == 4'h9) ? 2'd3 : 2'd2;
      4'h1: pmc_len = 2'd2;
      4'h2: pmc_len = (hi <= 4'h1) ? 2'd3 :
        (hi <= 4'h3 || hi >= 4'hE) ? 2'd1 : 2'd2;
      4'h3: pmc_len = (hi >= 4'h4 && hi <= 4'h6) ? 2'd3 : 2'd1;
      4'h4: pmc_len = (hi == 4'hB) ? 2'd3 :
        ((hi >= 4'h2 && hi <= 4'h7) || hi == 4'h9) ? 2'd2 : 2'd1;
      4'h5: pmc_len = (hi == 4'h7 || hi == 4'h8 || hi == 4'hB ||
        hi == 4'hD) ? 2'd3 : (hi == 4'hA) ? 2'd1 : 2'd2;
      4'h6, 4'h7: pmc_len = (hi == 4'hB) ? 2'd3 :
        (hi == 4'h7 || hi == 4'h8 || hi == 4'hA) ? 2'd2 : 2'd1;
      default: pmc_len = (hi == 4'hB) ? 2'd3 :
        (hi == 4'h7 || hi == 4'h8 || hi == 4'hA || hi == 4'hD) ?
        2'd2 : 2'd1;
    endcase
  endfunction : pmc_len

  function automatic logic pmc_is_cond(input logic [7:0] op);
    pmc_is_cond = (op[3:0] == 4'h0 && op[7:4] >= 4'h1 &&
      op[7:4] <= 4'h7) ||
      (op[7:4] == 4'hB && op[3:0] >= 4'h4) ||
      (op[7:4] == 4'hD && (op[3:0] == 4'h5 || op[3:0] >= 4'h8));
  endfunction : pmc_is_cond

  // not-taken clock count; default is one clock per byte
  function automatic logic [3:0] pmc_cycles(input logic [7:0] op);
    logic [1:0] len;
    len = pmc_len(op);
    pmc_cycles = {2'b00, len}; // RULE3
    case (op)
      PMC_OP_DIVIDE: pmc_cycles = 4'd8; // RULE5
      PMC_OP_MULTIPLY_OP: pmc_cycles = 4'd4;
      PMC_OP_RETURN, PMC_OP_RETURN_INT: pmc_cycles = 4'd5;
      PMC_OP_LONG_CALL, PMC_OP_LONG_JUMP: pmc_cycles = 4'd4;
      PMC_OP_SHORT_JUMP, PMC_OP_JUMP_INDEXED: pmc_cycles = 4'd3;
      8'h83, 8'h93, 8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3:
        pmc_cycles = 4'd3; // RULE8
      8'hB6, 8'hB7: pmc_cycles = 4'd4;
      default:
      begin
        if (op[3:0] == 4'h1)
          pmc_cycles = 4'd3;
        else if ((op[3:0] == 4'h6 || op[3:0] == 4'h7) && len == 2'd1)
          pmc_cycles = 4'd2; // indirect RAM needs an extra read clock
      end
    endcase
  endfunction : pmc_cycles

  always_comb
  begin
    o_timing.len = pmc_len(i_opcode); // RULE1
    o_timing.cycles = pmc_cycles(i_opcode); // RULE6
    o_timing.cond = pmc_is_cond(i_opcode);
  end

endmodule : pmc_cycle_decode

// File: verilog/pmc_core_timing.sv
// pipelined core sequencer with flash byte access, data RAM and debug port
`timescale 1ns/1ps
module pmc_core_timing (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // program flash
  output logic [15:0] o_code_addr,
  input wire logic [7:0] i_code_byte,
  output logic o_flash_wr,
  output logic [15:0] o_flash_waddr,
  output logic [7:0] o_flash_wdata,
  // execution datapath
  output pmc_pkg::pmc_exec_t o_exec,
  output logic [3:0] o_cycle,
  output logic o_retire,
  input wire logic i_branch_taken,
  input wire logic [15:0] i_branch_target,
  input wire logic i_code_rd_req,
  input wire logic [15:0] i_code_rd_addr,
  input wire logic i_flash_wr_req,
  input wire logic [15:0] i_flash_wr_addr,
  input wire logic [7:0] i_flash_wr_data,
  // internal data memory
  input wire pmc_pkg::pmc_dmem_req_t i_dmem,
  output logic [7:0] o_dmem_rdata,
  // serial debug port
  input wire logic i_jtag_tck,
  input wire logic i_jtag_tms,
  input wire logic i_jtag_tdi,
  output logic o_jtag_tdo,
  // debug status
  output logic o_halted
);
  import pmc_pkg::*;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  pmc_state_t state;
  logic [15:0] pc;
  logic [3:0] cnt;
  logic [7:0] opcode_q;
  logic [7:0] op1;
  logic [7:0] op2;
  logic taken_q;
  logic halt_req;
  logic bp_skip;
  logic bp_en;
  logic [15:0] bp_addr;
  logic wp_en;
  logic [7:0] wp_addr;
  logic tck_q;
  logic [PMC_DBG_W-1:0] sh;
  logic [7:0] ram [PMC_RAM_BYTES];
  logic [7:0] sfr [PMC_SFR_BYTES];

  // ---------------------------------------------------------------------
  // decode and cycle control
  // ---------------------------------------------------------------------
  logic [7:0] cur_op;
  pmc_timing_t timing;
  logic [3:0] cyc_m1;
  logic bp_hit;
  logic start;
  logic busy;
  logic extend;
  logic last;
  logic taken_final;
  logic [15:0] next_pc;

  assign cur_op = (cnt == 4'd0) ? i_code_byte : opcode_q;

  pmc_cycle_decode u_decode (
    .i_opcode(cur_op),
    .o_timing(timing)
  );

  assign cyc_m1 = timing.cycles - 4'd1;
  // resuming from a breakpoint must not trap on the same address again
  assign bp_hit = bp_en && (pc == bp_addr) && !bp_skip; // RULE10
  assign start = (cnt == 4'd0) && ((state == ST_RUN && !bp_hit &&
    !halt_req) || state == ST_STEP);
  assign busy = start || (cnt != 4'd0);
  assign extend = busy && timing.cond && i_branch_taken &&
    (cnt == cyc_m1); // RULE4
  assign last = busy && ((cnt == cyc_m1 && !extend) ||
    cnt == timing.cycles); // RULE2
  assign taken_final = timing.cond ? taken_q : i_branch_taken;
  assign next_pc = taken_final ? i_branch_target :
    pc + {14'h0000, timing.len};

  // a one-clock instruction retires in the clock it is fetched
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      cnt <= 4'd0;
    else if (last)
      cnt <= 4'd0; // RULE7
    else if (busy)
      cnt <= cnt + 4'd1;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      pc <= PMC_RESET_PC;
    else if (last)
      pc <= next_pc;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      taken_q <= 1'b0;
    else if (last)
      taken_q <= 1'b0;
    else if (extend)
      taken_q <= 1'b1;
  end

  // operands arrive one byte per clock behind the opcode
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      opcode_q <= 8'h00;
      op1 <= 8'h00;
      op2 <= 8'h00;
    end
    else
    begin
      if (start)
        opcode_q <= i_code_byte;
      if (cnt == 4'd1 && timing.len >= 2'd2)
        op1 <= i_code_byte; // RULE3
      if (cnt == 4'd2 && timing.len == 2'd3)
        op2 <= i_code_byte;
    end
  end

  // ---------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------
  pmc_dbg_word_t dbg_word;
  logic tck_rise;
  logic dbg_exec;
  logic [3:0] dbg_cmd;
  logic watch_hit;

  assign dbg_word = sh;
  assign tck_rise = i_jtag_tck && !tck_q;
  assign dbg_exec = tck_rise && i_jtag_tms; // RULE9
  assign dbg_cmd = dbg_exec ? dbg_word.cmd : DBG_NOP;
  assign watch_hit = wp_en && i_dmem.wr && !i_dmem.sfr &&
    (i_dmem.addr == wp_addr);

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      state <= ST_RUN;
    else
    begin
      case (state)
        ST_RUN:
          if (cnt == 4'd0 && (bp_hit || halt_req))
            state <= ST_HALT; // RULE10
        ST_STEP:
          if (last)
            state <= ST_HALT;
        ST_HALT:
          if (dbg_cmd == DBG_RUN)
            state <= ST_RUN;
          else if (dbg_cmd == DBG_STEP)
            state <= ST_STEP;
        default:
          state <= ST_RUN;
      endcase
    end
  end

  // a new halt request outranks the clear on entry to halt
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      halt_req <= 1'b0;
    else if (dbg_cmd == DBG_HALT || watch_hit)
      halt_req <= 1'b1;
    else if (state == ST_HALT)
      halt_req <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      bp_skip <= 1'b0;
    else if (state == ST_HALT)
      bp_skip <= 1'b1;
    else if (start)
      bp_skip <= 1'b0;
  end

  // break and watch comparators are private flops, not user resources
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      bp_en <= 1'b0;
      bp_addr <= 16'h0000;
      wp_en <= 1'b0;
      wp_addr <= 8'h00;
    end
    else if (dbg_cmd == DBG_SET_BP)
    begin
      bp_en <= 1'b1;
      bp_addr <= dbg_word.addr; // RULE11
    end
    else if (dbg_cmd == DBG_SET_WP)
    begin
      wp_en <= 1'b1;
      wp_addr <= dbg_word.addr[7:0];
    end
    else if (dbg_cmd == DBG_CLR_BP)
    begin
      bp_en <= 1'b0;
      wp_en <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // internal RAM and special function registers
  // ---------------------------------------------------------------------
  logic dbg_halted;
  logic dbg_mem_wr;

  assign dbg_halted = (state == ST_HALT);
  // debug writes only land while halted, so the program never races them
  assign dbg_mem_wr = dbg_halted && (dbg_cmd == DBG_WR_MEM);

  always_ff @(posedge i_clk)
  begin
    if (i_dmem.wr)
    begin
      if (i_dmem.sfr)
        sfr[i_dmem.addr[6:0]] <= i_dmem.wdata; // RULE12
      else
        ram[i_dmem.addr] <= i_dmem.wdata;
    end
    else if (dbg_mem_wr)
    begin
      if (dbg_word.addr[8])
        sfr[dbg_word.addr[6:0]] <= dbg_word.data; // RULE10
      else
        ram[dbg_word.addr[7:0]] <= dbg_word.data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
      o_dmem_rdata <= 8'h00;
    else if (i_dmem.sfr)
      o_dmem_rdata <= sfr[i_dmem.addr[6:0]];
    else
      o_dmem_rdata <= ram[i_dmem.addr];
  end

  // ---------------------------------------------------------------------
  // program flash access
  // ---------------------------------------------------------------------
  // the data-phase read of a code move reuses the fetch port after
  // the opcode bytes are in
  always_comb
  begin
    if (dbg_halted && cnt == 4'd0)
      o_code_addr = dbg_word.addr;
    else if (i_code_rd_req && cnt != 4'd0)
      o_code_addr = i_code_rd_addr; // RULE8
    else
      o_code_addr = pc + {12'h000, cnt};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_flash_wr <= 1'b0;
      o_flash_waddr <= 16'h0000;
      o_flash_wdata <= 8'h00;
    end
    else if (i_flash_wr_req)
    begin
      o_flash_wr <= 1'b1; // RULE8
      o_flash_waddr <= i_flash_wr_addr;
      o_flash_wdata <= i_flash_wr_data;
    end
    else if (dbg_halted && dbg_cmd == DBG_WR_CODE)
    begin
      o_flash_wr <= 1'b1; // RULE9
      o_flash_waddr <= dbg_word.addr;
      o_flash_wdata <= dbg_word.data;
    end
    else
      o_flash_wr <= 1'b0;
  end

  // ---------------------------------------------------------------------
  // serial debug shift register
  // ---------------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb
  begin
    case (dbg_word.cmd)
      DBG_RD_MEM:
        rd_byte = dbg_word.addr[8] ? sfr[dbg_word.addr[6:0]] :
          ram[dbg_word.addr[7:0]];
      DBG_RD_CODE:
        rd_byte = dbg_halted ? i_code_byte : 8'h00;
      DBG_RD_PC:
        rd_byte = dbg_word.addr[0] ? pc[15:8] : pc[7:0];
      default:
        rd_byte = 8'h00;
    endcase
  end

  // bits enter lsb first; an edge with the mode line high executes
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tck_q <= 1'b0;
      sh <= '0;
    end
    else
    begin
      tck_q <= i_jtag_tck;
      if (dbg_exec)
        sh <= {19'h00000, dbg_halted, rd_byte}; // RULE10
      else if (tck_rise)
        sh <= {i_jtag_tdi, sh[PMC_DBG_W-1:1]};
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign o_jtag_tdo = sh[0];
  assign o_halted = dbg_halted;
  assign o_retire = last;
  assign o_cycle = cnt;
  assign o_exec = '{pc: pc, opcode: cur_op, op1: op1, op2: op2};

endmodule : pmc_core_timing

// File: verif/pmc_core_timing_checker.sv
// concurrent checks on the core timing block ports
`timescale 1ns/1ps
module pmc_core_timing_checker import pmc_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // observed ports
  input wire logic i_branch_taken,
  input wire logic i_flash_wr_req,
  input wire logic [15:0] i_flash_wr_addr,
  input wire logic [7:0] i_flash_wr_data,
  input wire pmc_pkg::pmc_exec_t o_exec,
  input wire logic [3:0] o_cycle,
  input wire logic o_retire,
  input wire logic o_flash_wr,
  input wire logic [15:0] o_flash_waddr,
  input wire logic [7:0] o_flash_wdata,
  input wire logic o_halted
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  a_retire_bound: assert property (o_retire |-> o_cycle <= 4'h7)
    else $error("retire past the eighth clock");
  a_cycle_count: assert property (o_cycle != 4'h0 && !o_retire |=>
    o_cycle == $past(o_cycle) + 4'h1) else $error("clock index skipped");
  a_fetch_next: assert property (o_retire |=> o_cycle == 4'h0)
    else $error("no fetch after retire");
  a_divide_eight: assert property (o_retire &&
    o_exec.opcode == PMC_OP_DIVIDE |-> o_cycle == 4'h7)
    else $error("divide not eight clocks");
  a_mul_four: assert property (o_retire &&
    o_exec.opcode == PMC_OP_MULTIPLY_OP |-> o_cycle == 4'h3)
    else $error("multiply not four clocks");
  a_three_byte: assert property (o_retire &&
    o_exec.opcode == 8'h75 |-> o_cycle == 4'h2)
    else $error("three byte op not three clocks");
  a_two_byte_pc: assert property (o_retire && !i_branch_taken &&
    o_exec.opcode == 8'h74 |=> o_exec.pc == $past(o_exec.pc) + 16'h2)
    else $error("pc not advanced by 2");
  a_branch_not_taken: assert property (o_cycle == 4'h1 &&
    o_exec.opcode == 8'h40 && !i_branch_taken |-> o_retire)
    else $error("untaken branch too long");
  a_branch_taken: assert property (o_cycle == 4'h1 &&
    o_exec.opcode == 8'h40 && i_branch_taken |->
    !o_retire ##1 (o_retire && o_cycle == 4'h2))
    else $error("taken branch not three clocks");
  a_flash_echo: assert property (i_flash_wr_req |=> o_flash_wr &&
    o_flash_waddr == $past(i_flash_wr_addr) &&
    o_flash_wdata == $past(i_flash_wr_data)) else $error("flash write lost");
  a_flash_cause: assert property (o_flash_wr && !$past(o_halted) |->
    $past(i_flash_wr_req)) else $error("spurious flash write");
  a_halt_quiet: assert property (o_halted |-> !o_retire)
    else $error("retire while halted");
  c_taken: cover property (o_retire && o_cycle == 4'h2 && i_branch_taken);
  c_divide: cover property (o_retire && o_exec.opcode == PMC_OP_DIVIDE);
  c_halted: cover property ($rose(o_halted));
  c_flash: cover property (o_flash_wr);
endmodule : pmc_core_timing_checker

bind pmc_core_timing pmc_core_timing_checker pmc_core_timing_checker_i (
  .i_clk(i_clk), .i_reset(i_reset), .i_branch_taken(i_branch_taken),
  .i_flash_wr_req(i_flash_wr_req), .i_flash_wr_addr(i_flash_wr_addr),
  .i_flash_wr_data(i_flash_wr_data), .o_exec(o_exec), .o_cycle(o_cycle),
  .o_retire(o_retire), .o_flash_wr(o_flash_wr),
  .o_flash_waddr(o_flash_waddr), .o_flash_wdata(o_flash_wdata),
  .o_halted(o_halted));

// File: verif/pmc_dbg_host.sv
// serial debug host model
`timescale 1ns/1ps
module pmc_dbg_host (
  // clock
  input wire logic i_clk,
  // serial port
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  initial o_tck = 1'b0;
  initial o_tms = 1'b0;
  initial o_tdi = 1'b0;
  // tck low two clocks, high one; tdo read while tck is low
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    o_tms <= tms;
    o_tdi <= tdi;
    o_tck <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
    tdo = i_tdo;
    @(posedge i_clk);
    o_tck <= 1'b1;
    @(posedge i_clk);
  endtask : tick
  task automatic xfer(input logic [27:0] w, output logic [27:0] rd);
    logic x;
    for (int i = 0; i < 28; i++)
      tick(1'b0, w[i], rd[i]);
    tick(1'b1, ~w[27], x);
    // clock stands still between words, data line toggles off
    o_tck <= 1'b0;
    o_tdi <= ~o_tdi;
    @(posedge i_clk);
  endtask : xfer
endmodule : pmc_dbg_host

// File: verif/test_pmc_core_timing.sv
// self-checking bench for the core timing block
`timescale 1ns/1ps
module test_pmc_core_timing;
  import pmc_pkg::*;
  localparam logic [7:0] OPS [8] = '{8'h00, 8'h74, 8'h75, PMC_OP_MULTIPLY_OP,
    PMC_OP_DIVIDE, 8'h40, 8'h93, 8'hF0};
  logic i_clk, i_reset, i_branch_taken, i_code_rd_req, i_flash_wr_req;
  logic [15:0] i_branch_target, i_code_rd_addr, i_flash_wr_addr;
  logic [15:0] o_code_addr, o_flash_waddr, exp_pc;
  logic [7:0] i_flash_wr_data, i_code_byte, o_dmem_rdata, o_flash_wdata;
  logic [3:0] o_cycle;
  logic o_retire, o_flash_wr, o_halted, o_jtag_tdo, tck, tms, tdi, checking;
  pmc_exec_t o_exec;
  pmc_dmem_req_t i_dmem;
  logic [7:0] prog [0:4095];
  logic [15:0] starts [0:63];
  logic [31:0] r;
  logic [27:0] rd;
  int error_cnt, checks_done, retires, n, a, k;

  assign i_code_byte = prog[o_code_addr[11:0]];
  always #4 i_clk = ~i_clk;

  pmc_core_timing pmc_core_timing_i (.i_clk(i_clk), .i_reset(i_reset),
    .o_code_addr(o_code_addr), .i_code_byte(i_code_byte),
    .o_flash_wr(o_flash_wr), .o_flash_waddr(o_flash_waddr),
    .o_flash_wdata(o_flash_wdata), .o_exec(o_exec), .o_cycle(o_cycle),
    .o_retire(o_retire), .i_branch_taken(i_branch_taken),
    .i_branch_target(i_branch_target), .i_code_rd_req(i_code_rd_req),
    .i_code_rd_addr(i_code_rd_addr), .i_flash_wr_req(i_flash_wr_req),
    .i_flash_wr_addr(i_flash_wr_addr), .i_flash_wr_data(i_flash_wr_data),
    .i_dmem(i_dmem), .o_dmem_rdata(o_dmem_rdata), .i_jtag_tck(tck),
    .i_jtag_tms(tms), .i_jtag_tdi(tdi), .o_jtag_tdo(o_jtag_tdo),
    .o_halted(o_halted));
  pmc_dbg_host pmc_dbg_host_i (.i_clk(i_clk), .o_tck(tck), .o_tms(tms),
    .o_tdi(tdi), .i_tdo(o_jtag_tdo));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [15:0] op_len(input logic [7:0] op);
    case (op)
      8'h74, 8'h40: return 16'h2;
      8'h75: return 16'h3;
      default: return 16'h1;
    endcase
  endfunction : op_len
  function automatic logic [31:0] op_clks(input logic [7:0] op, input logic tk);
    case (op)
      8'h00: return 32'h1;
      8'h74: return 32'h2;
      8'h75, 8'h93, 8'hF0: return 32'h3;
      PMC_OP_MULTIPLY_OP: return 32'h4;
      PMC_OP_DIVIDE: return 32'h8;
      default: return tk ? 32'h3 : 32'h2;
    endcase
  endfunction : op_clks
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic wait_halt(input logic want);
    n = 0;
    while (o_halted !== want && n < 400)
    begin
      @(negedge i_clk);
      n++;
    end
    check("halted", 32'(o_halted), 32'(want));
    if (n >= 400)
      test_done();
  endtask : wait_halt
  task automatic dbg(input logic [3:0] c, input logic [15:0] ad,
    input logic [7:0] d);
    pmc_dbg_host_i.xfer({c, ad, d}, rd);
  endtask : dbg
  task automatic dmem(input logic wr, input logic sfr, input logic [7:0] ad,
    input logic [7:0] d);
    @(posedge i_clk);
    i_dmem <= '{wr, sfr, ad, d};
    @(posedge i_clk);
    i_dmem.wr <= 1'b0;
    @(negedge i_clk);
  endtask : dmem

  // ---------------------------------------------------------------------
  // per-instruction clock and pc checks
  // ---------------------------------------------------------------------
  always @(negedge i_clk)
    if (checking && o_retire)
    begin
      check("clocks", 32'(o_cycle) + 32'h1,
        op_clks(o_exec.opcode, i_branch_taken));
      check("pc", 32'(o_exec.pc), 32'(exp_pc));
      // a taken outcome redirects any op in its last clock
      exp_pc = i_branch_taken ?
        i_branch_target : o_exec.pc + op_len(o_exec.opcode);
      retires++;
    end
  // datapath side: branch outcome held for a whole instruction
  always @(posedge i_clk)
    if (checking)
    begin
      r <= lfsr(r);
      if (o_retire)
      begin
        i_branch_taken <= r[3];
        i_branch_target <= starts[r[9:4]];
      end
      i_code_rd_req <= o_cycle == 4'h0 && o_exec.opcode == 8'h93;
      i_flash_wr_req <= o_cycle == 4'h0 && o_exec.opcode == 8'hF0 && !o_halted;
      i_code_rd_addr <= {4'h0, r[27:16]};
      i_flash_wr_addr <= r[31:16];
      i_flash_wr_data <= r[15:8];
    end

  initial
  begin
    i_clk = 1'b0;
    i_reset = 1'b1;
    {i_branch_taken, i_code_rd_req, i_flash_wr_req, checking} = 4'h0;
    {i_branch_target, i_code_rd_addr, i_flash_wr_addr} = 48'h0;
    i_flash_wr_data = 8'h00;
    i_dmem = '0;
    exp_pc = 16'h0000;
    r = 32'h6048;
    a = 0;
    k = 0;
    while (a < 4090)
    begin
      r = lfsr(r);
      if (k < 64)
        starts[k] = 16'(a);
      k++;
      prog[a] = OPS[r[2:0]];
      prog[a + 1] = r[15:8];
      prog[a + 2] = r[23:16];
      a += int'(op_len(OPS[r[2:0]]));
    end
    repeat (5) @(posedge i_clk);
    i_reset <= 1'b0;
    checking <= 1'b1;
    n = 0;
    while (retires < 300 && n < 5000)
    begin
      @(negedge i_clk);
      n++;
    end
    check("stream", 32'(n < 5000), 32'h1);
    if (n >= 5000)
      test_done();
    dmem(1'b1, 1'b0, 8'h7F, 8'hA5);
    dmem(1'b1, 1'b1, 8'h7F, 8'h3C);
    dmem(1'b1, 1'b0, 8'h13, 8'hC3);
    dmem(1'b1, 1'b0, 8'hFF, 8'h96);
    dmem(1'b0, 1'b0, 8'h7F, 8'h00);
    check("ram", 32'(o_dmem_rdata), 32'hA5);
    dmem(1'b0, 1'b1, 8'h7F, 8'h00);
    check("sfr", 32'(o_dmem_rdata), 32'h3C);
    dmem(1'b0, 1'b0, 8'hFF, 8'h00);
    check("ram top", 32'(o_dmem_rdata), 32'h96);
    // write while running must be ignored
    dbg(4'h8, 16'h0013, 8'h5A);
    dbg(4'h1, 16'h0000, 8'h00);
    wait_halt(1'b1);
    dbg(4'h7, 16'h0013, 8'h00);
    dbg(4'h0, 16'h0000, 8'h00);
    check("dbg refused", 32'(rd[8:0]), 32'h1C3);
    dbg(4'h8, 16'h0012, 8'h69);
    dbg(4'h7, 16'h0012, 8'h00);
    dbg(4'h0, 16'h0000, 8'h00);
    check("dbg ram", 32'(rd[8:0]), 32'h169);
    dbg(4'h7, 16'h017F, 8'h00);
    dbg(4'h0, 16'h0000, 8'h00);
    check("dbg sfr", 32'(rd[8:0]), 32'h13C);
    dbg(4'h9, 16'h0005, 8'h00);
    dbg(4'h0, 16'h0000, 8'h00);
    check("dbg code", 32'(rd[8:0]), 32'({1'b1, prog[5]}));
    dbg(4'hA, 16'h0100, 8'h77);
    check("flash addr", 32'(o_flash_waddr), 32'h0100);
    check("flash data", 32'(o_flash_wdata), 32'h77);
    k = retires;
    dbg(4'h3, 16'h0000, 8'h00);
    wait_halt(1'b1);
    check("step", 32'(retires - k), 32'h1);
    dbg(4'hB, 16'h0000, 8'h00);
    dbg(4'h0, 16'h0000, 8'h00);
    check("dbg pc", 32'(rd[8:0]), 32'({1'b1, exp_pc[7:0]}));
    dbg(4'h2, 16'h0000, 8'h00);
    wait_halt(1'b0);
    repeat (50) @(negedge i_clk);
    test_done();
  end
endmodule : test_pmc_core_timing
